// *** design/rst_pd_strap_pkg.sv ***
// Behaviour
// - test reset low asynchronously clears test logic
// - reset held 1 us starts full reset
// - hardware reset restores all register defaults
// - hardware reset re-acquires every strap option
// - dual pin defaults to power-down input
// - low level on pin requests power-down
// - interrupt mode drives pin open-drain low
// - interrupt function needs software configuration
// - straps sampled while reset is applied
// - five address straps latched into port control
// - every address 0 to 31 accepted
// - strapped address zero selects isolate mode
// - software address zero never selects isolate
// - unstrapped default address is one
package rst_pd_strap_pkg;
  localparam int ADDR_W = 5;
  localparam int CLK_NS = 25;
  localparam int RST_MIN_NS = 1000;
  localparam int RST_MIN_CYC = (RST_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int RST_CNT_W = 6;
  localparam logic [ADDR_W-1:0] ADDR_DEFAULT = 5'h01;
  localparam logic [ADDR_W-1:0] ADDR_ISOLATE = 5'h00;
  localparam int HANDBACK_CYC = 2;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic isolate;
    logic irq_mode;
  } port_ctrl_s;

  localparam port_ctrl_s PORT_CTRL_RST = '{addr: ADDR_DEFAULT, isolate: 1'b0, irq_mode: 1'b0};

  typedef enum logic [2:0] {
    ST_RESET = 3'b001,
    ST_SETTLE = 3'b010,
    ST_RUN = 3'b100
  } seq_e;
endpackage : rst_pd_strap_pkg

// *** design/reset_powerdown_strap_latch.sv ***
`timescale 1ns/1ps
module reset_powerdown_strap_latch (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic reset_pin_n,
  input wire logic test_rst_n,
  input wire logic [rst_pd_strap_pkg::ADDR_W-1:0] station_addr_strap,
  input wire logic powerdown_or_irq_pin_i,
  output logic powerdown_or_irq_pin_o,
  output logic powerdown_or_irq_pin_oe,
  input wire logic cfg_wr,
  input wire logic cfg_irq_mode,
  input wire logic [rst_pd_strap_pkg::ADDR_W-1:0] cfg_addr,
  input wire logic cfg_addr_wr,
  input wire logic irq_cond,
  output rst_pd_strap_pkg::port_ctrl_s port_control_register,
  output logic core_reset,
  output logic test_logic_reset,
  output logic power_down,
  output logic strap_oe_allow
);
  import rst_pd_strap_pkg::*;

  logic [2:0] rp_sync_r, rp_sync_nxt;
  logic [2:0] pd_sync_r, pd_sync_nxt;
  logic [ADDR_W-1:0] strap_s1_r, strap_s1_nxt;
  logic [ADDR_W-1:0] strap_s2_r, strap_s2_nxt;
  logic [ADDR_W-1:0] strap_s3_r, strap_s3_nxt;
  logic [ADDR_W-1:0] strap_q_r, strap_q_nxt;
  logic [RST_CNT_W-1:0] low_cnt_r, low_cnt_nxt;
  logic [1:0] settle_r, settle_nxt;
  seq_e state_r, state_nxt;
  port_ctrl_s pc_r, pc_nxt;
  logic rp_low_r, rp_low_nxt;
  logic pd_low_r, pd_low_nxt;
  logic core_reset_r, core_reset_nxt;
  logic pd_r, pd_nxt;
  logic tr1_r, tr1_nxt;
  logic tr2_r, tr2_nxt;
  logic long_low;

  // filtered level: follows the pin once stages two and three agree
  function automatic logic agree_level(input logic [2:0] sync, input logic held);
    logic level;
    level = held;
    if (sync[1] == sync[2]) begin
      level = sync[2];
    end
    return level;
  endfunction : agree_level

  // saturating low-time count, cleared while the pin is high
  function automatic logic [RST_CNT_W-1:0] sat_step(input logic [RST_CNT_W-1:0] cnt,
      input logic run);
    logic [RST_CNT_W-1:0] res;
    res = '0;
    if (run) begin
      res = cnt;
      if (cnt < RST_CNT_W'(RST_MIN_CYC)) begin
        res = cnt + 1'b1;
      end
    end
    return res;
  endfunction : sat_step

  // only a strapped zero address isolates
  function automatic logic strap_isolates(input logic [ADDR_W-1:0] addr);
    return addr == ADDR_ISOLATE;
  endfunction : strap_isolates

  // test reset: asynchronous assert, synchronous release
  always_comb begin
    tr1_nxt = 1'b0;
    tr2_nxt = tr1_r;
  end

  always_ff @(posedge core_clk or negedge test_rst_n) begin
    if (!test_rst_n) begin
      tr1_r <= 1'b1;
      tr2_r <= 1'b1;
    end else begin
      tr1_r <= tr1_nxt;
      tr2_r <= tr2_nxt;
    end
  end

  assign test_logic_reset = tr2_r;

  // reset pin synchroniser, starts as if the pin were low
  always_comb begin
    rp_sync_nxt = {rp_sync_r[1:0], reset_pin_n};
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rp_sync_r <= 3'b000;
    end else begin
      rp_sync_r <= rp_sync_nxt;
    end
  end

  // power-down pin synchroniser
  always_comb begin
    pd_sync_nxt = {pd_sync_r[1:0], powerdown_or_irq_pin_i};
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pd_sync_r <= 3'b111;
    end else begin
      pd_sync_r <= pd_sync_nxt;
    end
  end

  // strap pin synchroniser
  always_comb begin
    strap_s1_nxt = station_addr_strap;
    strap_s2_nxt = strap_s1_r;
    strap_s3_nxt = strap_s2_r;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      strap_s1_r <= ADDR_DEFAULT;
      strap_s2_r <= ADDR_DEFAULT;
      strap_s3_r <= ADDR_DEFAULT;
    end else begin
      strap_s1_r <= strap_s1_nxt;
      strap_s2_r <= strap_s2_nxt;
      strap_s3_r <= strap_s3_nxt;
    end
  end

  // filtered reset pin level
  always_comb begin
    rp_low_nxt = ~agree_level(rp_sync_r, ~rp_low_r);
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rp_low_r <= 1'b1;
    end else begin
      rp_low_r <= rp_low_nxt;
    end
  end

  // filtered power-down pin level
  always_comb begin
    pd_low_nxt = ~agree_level(pd_sync_r, ~pd_low_r);
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pd_low_r <= 1'b0;
    end else begin
      pd_low_r <= pd_low_nxt;
    end
  end

  // filtered strap levels, sampled all through reset
  always_comb begin
    strap_q_nxt = strap_q_r;
    for (int i = 0; i < ADDR_W; i++) begin
      strap_q_nxt[i] = agree_level({strap_s3_r[i], strap_s2_r[i], strap_s1_r[i]}, strap_q_r[i]);
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      strap_q_r <= ADDR_DEFAULT;
    end else begin
      strap_q_r <= strap_q_nxt;
    end
  end

  // reset pin low-time counter
  always_comb begin
    low_cnt_nxt = sat_step(low_cnt_r, rp_low_r);
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      low_cnt_r <= '0;
    end else begin
      low_cnt_r <= low_cnt_nxt;
    end
  end

  assign long_low = rp_low_r && (low_cnt_r >= RST_CNT_W'(RST_MIN_CYC));

  // reset sequencer
  always_comb begin
    state_nxt = state_r;
    settle_nxt = settle_r;
    case (state_r)
      ST_RESET: begin
        if (!rp_low_r) begin
          settle_nxt = 2'(HANDBACK_CYC);
          state_nxt = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        if (settle_r != 2'h0) begin
          settle_nxt = settle_r - 1'b1;
        end else begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        state_nxt = ST_RUN;
      end
      default: begin
        state_nxt = ST_RESET;
      end
    endcase
    if (long_low) begin
      state_nxt = ST_RESET;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_r <= ST_RESET;
      settle_r <= 2'h0;
    end else begin
      state_r <= state_nxt;
      settle_r <= settle_nxt;
    end
  end

  // core reset output
  always_comb begin
    core_reset_nxt = core_reset_r;
    case (state_r)
      ST_RESET: begin
        core_reset_nxt = 1'b1;
      end
      ST_SETTLE: begin
        core_reset_nxt = 1'b0;
      end
      ST_RUN: begin
        core_reset_nxt = core_reset_r;
      end
      default: begin
        core_reset_nxt = 1'b1;
      end
    endcase
    if (long_low) begin
      core_reset_nxt = 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      core_reset_r <= 1'b1;
    end else begin
      core_reset_r <= core_reset_nxt;
    end
  end

  // port control register
  always_comb begin
    pc_nxt = pc_r;
    case (state_r)
      ST_RESET: begin
        pc_nxt = PORT_CTRL_RST;
        if (!rp_low_r) begin
          pc_nxt.addr = strap_q_r;
          pc_nxt.isolate = strap_isolates(strap_q_r);
        end
      end
      ST_SETTLE: begin
        pc_nxt = pc_r;
      end
      ST_RUN: begin
        if (cfg_wr) begin
          pc_nxt.irq_mode = cfg_irq_mode;
        end
        if (cfg_addr_wr) begin
          pc_nxt.addr = cfg_addr;
        end
      end
      default: begin
        pc_nxt = PORT_CTRL_RST;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pc_r <= PORT_CTRL_RST;
    end else begin
      pc_r <= pc_nxt;
    end
  end

  // power-down request, only while the pin is an input
  always_comb begin
    pd_nxt = 1'b0;
    if ((state_r == ST_RUN) && !long_low) begin
      pd_nxt = !pc_r.irq_mode && pd_low_r;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pd_r <= 1'b0;
    end else begin
      pd_r <= pd_nxt;
    end
  end

  assign port_control_register = pc_r;
  assign core_reset = core_reset_r;
  assign power_down = pd_r;
  assign strap_oe_allow = (state_r == ST_RUN);
  assign powerdown_or_irq_pin_o = 1'b0;
  assign powerdown_or_irq_pin_oe = (state_r == ST_RUN) && pc_r.irq_mode && irq_cond;
endmodule : reset_powerdown_strap_latch

// *** tb/reset_powerdown_strap_latch_chk.sv ***
`timescale 1ns/1ps
module rpsl_chk (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic test_rst_n,
  input wire logic powerdown_or_irq_pin_i,
  input wire logic powerdown_or_irq_pin_o,
  input wire logic powerdown_or_irq_pin_oe,
  input wire logic cfg_wr,
  input wire logic cfg_irq_mode,
  input wire logic cfg_addr_wr,
  input wire logic irq_cond,
  input wire rst_pd_strap_pkg::port_ctrl_s port_control_register,
  input wire logic test_logic_reset,
  input wire logic power_down,
  input wire logic strap_oe_allow
);
  import rst_pd_strap_pkg::*;
  wire port_ctrl_s pc = port_control_register;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence pd_held;
    (!powerdown_or_irq_pin_i && !pc.irq_mode && strap_oe_allow)[*6];
  endsequence
  AST_OE: assert property (powerdown_or_irq_pin_oe ==
    (strap_oe_allow && pc.irq_mode && irq_cond)) else $error("oe");
  AST_PO: assert property (powerdown_or_irq_pin_o == 1'h0) else $error("o");
  AST_TRST: assert property (!test_rst_n |-> test_logic_reset) else $error("trst");
  AST_ISO: assert property ($rose(strap_oe_allow) |->
    pc.isolate == (pc.addr == 5'h00)) else $error("iso");
  AST_DEF: assert property ($rose(strap_oe_allow) |-> !pc.irq_mode) else $error("def");
  AST_SWA: assert property (cfg_addr_wr && strap_oe_allow |=>
    $stable(pc.isolate)) else $error("swa");
  AST_CFG: assert property (cfg_wr && strap_oe_allow |=>
    pc.irq_mode == $past(cfg_irq_mode)) else $error("cfg");
  AST_PD: assert property (pd_held |-> power_down) else $error("pd");
endmodule : rpsl_chk
bind reset_powerdown_strap_latch rpsl_chk chk (
  .core_clk(core_clk),
  .rst(rst),
  .test_rst_n(test_rst_n),
  .powerdown_or_irq_pin_i(powerdown_or_irq_pin_i),
  .powerdown_or_irq_pin_o(powerdown_or_irq_pin_o),
  .powerdown_or_irq_pin_oe(powerdown_or_irq_pin_oe),
  .cfg_wr(cfg_wr),
  .cfg_irq_mode(cfg_irq_mode),
  .cfg_addr_wr(cfg_addr_wr),
  .irq_cond(irq_cond),
  .port_control_register(port_control_register),
  .test_logic_reset(test_logic_reset),
  .power_down(power_down),
  .strap_oe_allow(strap_oe_allow)
);

// *** tb/host_model.sv ***
`timescale 1ns/1ps
module host_model (
  input wire logic core_clk,
  input wire logic pd_req,
  input wire logic pin_oe,
  output logic pin_level,
  output logic reset_pin_n
);
  assign pin_level = !(pd_req || pin_oe);
  initial reset_pin_n = 1'h1;
  task automatic hw_reset(input int cyc);
    @(negedge core_clk);
    reset_pin_n = 1'h0;
    repeat (cyc) @(negedge core_clk);
    reset_pin_n = 1'h1;
  endtask : hw_reset
endmodule : host_model

// *** tb/reset_powerdown_strap_latch_tb.sv ***
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin miscompares++; \
  $display("mismatch %0t %h %h", $time, a, b); end end
module reset_powerdown_strap_latch_tb;
  import rst_pd_strap_pkg::*;
  logic core_clk = 1'h0, rst = 1'h1, test_rst_n = 1'h1, cfg_wr = 1'h0, cfg_irq_mode = 1'h0;
  logic cfg_addr_wr = 1'h0, irq_cond = 1'h0, pd_req = 1'h0, reset_pin_n, powerdown_or_irq_pin_i;
  logic powerdown_or_irq_pin_o, powerdown_or_irq_pin_oe, core_reset, test_logic_reset;
  logic power_down, strap_oe_allow;
  logic [4:0] station_addr_strap = 5'h12, cfg_addr = 5'h00, last;
  port_ctrl_s port_control_register;
  int miscompares = 0, n_tests = 0, seed = 55736;
  initial forever #12.5 core_clk = ~core_clk;
  host_model host (.core_clk(core_clk), .pd_req(pd_req), .pin_oe(powerdown_or_irq_pin_oe),
    .pin_level(powerdown_or_irq_pin_i), .reset_pin_n(reset_pin_n));
  reset_powerdown_strap_latch uut (.core_clk(core_clk), .rst(rst), .reset_pin_n(reset_pin_n),
    .test_rst_n(test_rst_n), .station_addr_strap(station_addr_strap),
    .powerdown_or_irq_pin_i(powerdown_or_irq_pin_i),
    .powerdown_or_irq_pin_o(powerdown_or_irq_pin_o),
    .powerdown_or_irq_pin_oe(powerdown_or_irq_pin_oe), .cfg_wr(cfg_wr),
    .cfg_irq_mode(cfg_irq_mode), .cfg_addr(cfg_addr), .cfg_addr_wr(cfg_addr_wr),
    .irq_cond(irq_cond), .port_control_register(port_control_register),
    .core_reset(core_reset), .test_logic_reset(test_logic_reset), .power_down(power_down),
    .strap_oe_allow(strap_oe_allow));
  task automatic complete_run;
    if (miscompares == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  task automatic wait_run;
    for (int i = 0; i < 80 && strap_oe_allow !== 1'h1; i++) @(negedge core_clk);
    if (strap_oe_allow !== 1'h1) begin
      miscompares++;
      complete_run();
    end
  endtask : wait_run
  task automatic strap_check(input logic [4:0] s);
    station_addr_strap = s;
    host.hw_reset(60);
    wait_run();
    `CHK(port_control_register.addr, s)
    `CHK(port_control_register.isolate, s == 5'h00)
    `CHK(port_control_register.irq_mode, 1'h0)
    `CHK(core_reset, 1'h0)
  endtask : strap_check
  initial begin
    repeat (4) @(negedge core_clk);
    `CHK(port_control_register.addr, 5'h01)
    `CHK(core_reset, 1'h1)
    rst = 1'h0;
    wait_run();
    `CHK(port_control_register.addr, 5'h12)
    strap_check(5'h00);
    repeat (4) strap_check(5'($random(seed)));
    strap_check(5'h1f);
    last = station_addr_strap;
    station_addr_strap = 5'h0a;
    host.hw_reset(8);
    repeat (10) @(negedge core_clk);
    `CHK(port_control_register.addr, last)
    cfg_addr_wr = 1'h1;
    @(negedge core_clk);
    cfg_addr_wr = 1'h0;
    @(negedge core_clk);
    `CHK(port_control_register, {5'h00, 1'h0, 1'h0})
    pd_req = 1'h1;
    repeat (8) @(negedge core_clk);
    `CHK(power_down, 1'h1)
    pd_req = 1'h0;
    cfg_wr = 1'h1;
    cfg_irq_mode = 1'h1;
    irq_cond = 1'h1;
    @(negedge core_clk);
    cfg_wr = 1'h0;
    repeat (2) @(negedge core_clk);
    `CHK(powerdown_or_irq_pin_i, 1'h0)
    irq_cond = 1'h0;
    @(negedge core_clk);
    `CHK(powerdown_or_irq_pin_i, 1'h1)
    strap_check(5'h01);
    test_rst_n = 1'h0;
    @(negedge core_clk);
    `CHK(test_logic_reset, 1'h1)
    test_rst_n = 1'h1;
    repeat (3) @(negedge core_clk);
    `CHK(test_logic_reset, 1'h0)
    complete_run();
  end
endmodule : reset_powerdown_strap_latch_tb
